// [hdl/trf_io_flags.sv]
// Remote I/O handshake flags behind an AHB-Lite port
// Operation
// - Tuning status high while auto or self-tuning runs.
// - Instruction starts auto tuning; status self-clears at end.
// - Ch3/4 heating-cooling and ch2 mix status only in expanded mode.
// - Self-tuning only in standard control; status spans it.
// - Group rise status holds until the channel switches to its own PID.
// - Offset latch done set on store, cleared when its request falls.
// - Gain latch done set on store, cleared when its request falls.
// - Mirror output and ON-delay states; second set for heating-cooling.
// - ON-delay flag follows output flag after the configured delay.
// - Initial-data request applies parameters, then completed flag rises.
// - Initial-data request rejected with error 0003H if any channel runs.
// - Clear request on-then-off clears error only for 0003H/FFFFH or 0006H.
// - Clear request keeps history; history command erases it.
// - Error flag high on moderate or major error cause, and while a reported error stays latched.
// - Operation monitor flag high while the channel operates.
`timescale 1ns/1ps
module trf_io_flags #(
    parameter int DLY_UNIT_CYC = trf_pkg::DLY_UNIT_CYC // Cycles per ON-delay unit
) (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    output logic irq, // Level interrupt
    input wire logic [3:0] chanRunning, // Channel operating
    input wire logic [3:0] autoTuneDone, // Auto tuning finished pulse
    output logic [3:0] autoTuneStart, // Auto tuning start pulse
    output logic [3:0] selfTuneEnable, // Self-tuning permitted
    input wire logic [3:0] selfTuneStart, // Self-tuning began pulse
    input wire logic [3:0] selfTuneDone, // Self-tuning finished pulse
    input wire logic [3:0] riseStart, // Simultaneous rise began pulse
    input wire logic [3:0] ownPidSwitch, // Switched to own PID pulse
    input wire logic [3:0] offsetStored, // Offset value stored pulse
    input wire logic [3:0] gainStored, // Gain value stored pulse
    input wire logic [3:0] outState1, // First transistor output state
    input wire logic [3:0] outState2, // Second transistor output state
    input wire logic errCause, // Moderate or major error present
    input wire logic errEvent, // Latched error report pulse
    input wire logic [15:0] errCodeIn, // Reported error code
    input wire logic [15:0] errAddrIn, // Reported error address
    output logic paramApply, // Apply buffered parameters pulse
    input wire logic paramApplied // Parameters now in effect pulse
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] fallEdge(input logic [3:0] prev, input logic [3:0] cur);
        fallEdge = prev & ~cur;
    endfunction : fallEdge

    function automatic logic [3:0] riseEdge(input logic [3:0] prev, input logic [3:0] cur);
        riseEdge = ~prev & cur;
    endfunction : riseEdge

    typedef enum logic [1:0] {INIT_IDLE, INIT_APPLY, INIT_WAIT, INIT_DONE} trf_init_t;

    localparam int IRQ_W_LOC = trf_pkg::IRQ_W;
    trf_pkg::trf_cfg_t cfg_q;
    trf_pkg::trf_req_t req_q, smp_q, prv_q;
    logic smpValid_q;
    logic [15:0] refCnt_q;
    logic [15:0] unitCnt_q;
    logic unitTick;
    logic [3:0] tune_q, rise_q, offDone_q, gainDone_q, provided, tuneFlag;
    logic [3:0] dly1, dly2;
    trf_init_t initSt_q;
    logic initDone_q, errLatched_q;
    logic [15:0] errCode_q, errAddr_q;
    logic [7:0] hist_q;
    logic [IRQ_W_LOC-1:0] irqStat_q, irqMask_q, irqEv;
    logic [7:0] addr_q;
    logic wrPend_q;
    logic addrPh;
    logic rdStat;
    logic initRise, clrFall, anyRun, rejectEv, errSetEv;
    logic errFlag;

    // ------------------------------------------------------------
    // Link refresh and delay unit ticks
    // ------------------------------------------------------------
    // Refresh counter paces request sampling
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refCnt_q <= 16'h0000;
        end else if (refCnt_q == 16'(trf_pkg::REFRESH_CYC - 1)) begin
            refCnt_q <= 16'h0000;
        end else begin
            refCnt_q <= refCnt_q + 16'h0001;
        end
    end

    // Delay unit prescaler for ON-delay timers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unitCnt_q <= 16'h0000;
        end else if (unitTick) begin
            unitCnt_q <= 16'h0000;
        end else begin
            unitCnt_q <= unitCnt_q + 16'h0001;
        end
    end
    assign unitTick = (unitCnt_q == 16'(DLY_UNIT_CYC - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smp_q <= '0;
            prv_q <= '0;
            smpValid_q <= 1'b0;
        end else begin
            smpValid_q <= (refCnt_q == 16'h0000);
            if (refCnt_q == 16'h0000) begin
                prv_q <= smp_q;
                smp_q <= req_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Tuning status
    // ------------------------------------------------------------
    // expanded-mode gating
    always_comb begin
        provided = 4'hF;
        if (trf_pkg::trf_mode_t'(cfg_q.mode) == trf_pkg::MODE_HEATCOOL && !cfg_q.expanded) begin
            provided[3:2] = 2'b00;
        end
        if (trf_pkg::trf_mode_t'(cfg_q.mode) == trf_pkg::MODE_MIX && !cfg_q.expanded) begin
            provided[1] = 1'b0;
        end
    end

    assign selfTuneEnable = cfg_q.selfTune
        & {4{trf_pkg::trf_mode_t'(cfg_q.mode) == trf_pkg::MODE_STANDARD}};

    // start auto tuning on instruction rise
    assign autoTuneStart = smpValid_q ? riseEdge(prv_q.tuningInstructionFlag,
        smp_q.tuningInstructionFlag) & provided & ~tune_q : 4'h0;

    // tuning status set on start, cleared on completion
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tune_q <= 4'h0;
        end else begin
            tune_q <= (tune_q & ~autoTuneDone & ~selfTuneDone) | autoTuneStart
                | (selfTuneStart & selfTuneEnable);
        end
    end
    assign tuneFlag = tune_q & provided;

    // group rise held until own PID switch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rise_q <= 4'h0;
        end else begin
            rise_q <= (rise_q & ~ownPidSwitch) | riseStart;
        end
    end

    // ------------------------------------------------------------
    // Two-point correction latch handshakes
    // ------------------------------------------------------------
    // set on store, clear on sampled request fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            offDone_q <= 4'h0;
            gainDone_q <= 4'h0;
        end else begin
            offDone_q <= (offDone_q & ~(smpValid_q ? fallEdge(prv_q.offsetLatchRequest,
                smp_q.offsetLatchRequest) : 4'h0)) | offsetStored;
            gainDone_q <= (gainDone_q & ~(smpValid_q ? fallEdge(prv_q.gainLatchRequest,
                smp_q.gainLatchRequest) : 4'h0)) | gainStored;
        end
    end

    // ------------------------------------------------------------
    // Output mirrors with ON-delay
    // ------------------------------------------------------------
    // one delay follower per output state
    for (genvar i = 0; i < 4; i++) begin : g_dly
        trf_on_delay u_dly1 (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .tick(unitTick),
            .delayUnits(cfg_q.onDelay),
            .src(outState1[i]),
            .dly(dly1[i])
        );
        trf_on_delay u_dly2 (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .tick(unitTick),
            .delayUnits(cfg_q.onDelay),
            .src(outState2[i]),
            .dly(dly2[i])
        );
    end

    // ------------------------------------------------------------
    // Initial data setting and error handling
    // ------------------------------------------------------------
    assign anyRun = |chanRunning;
    assign initRise = smpValid_q && smp_q.initialDataRequest && !prv_q.initialDataRequest;
    assign clrFall = smpValid_q && !smp_q.errorClearRequest && prv_q.errorClearRequest;
    assign rejectEv = initRise && anyRun && initSt_q == INIT_IDLE;
    assign paramApply = (initSt_q == INIT_APPLY);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            initSt_q <= INIT_IDLE;
        end else begin
            unique case (initSt_q)
                INIT_IDLE: begin
                    if (initRise && !anyRun) begin
                        initSt_q <= INIT_APPLY;
                    end
                end
                INIT_APPLY: begin
                    initSt_q <= INIT_WAIT;
                end
                INIT_WAIT: begin
                    if (paramApplied) begin
                        initSt_q <= INIT_DONE;
                    end
                end
                INIT_DONE: begin
                    if (smpValid_q && !smp_q.initialDataRequest) begin
                        initSt_q <= INIT_IDLE;
                    end
                end
            endcase
        end
    end
    assign initDone_q = (initSt_q == INIT_DONE);

    assign errSetEv = rejectEv || errEvent;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            errLatched_q <= 1'b0;
            errCode_q <= trf_pkg::ERR_NONE;
            errAddr_q <= trf_pkg::ERR_NONE;
        end else if (errSetEv) begin
            errLatched_q <= 1'b1;
            errCode_q <= rejectEv ? trf_pkg::ERR_BUSY : errCodeIn;
            errAddr_q <= rejectEv ? trf_pkg::ERR_ADDR_ALL : errAddrIn;
        end else if (clrFall && ((errCode_q == trf_pkg::ERR_BUSY
                && errAddr_q == trf_pkg::ERR_ADDR_ALL) || errCode_q == trf_pkg::ERR_CLEARABLE)) begin
            errLatched_q <= 1'b0;
            errCode_q <= trf_pkg::ERR_NONE;
            errAddr_q <= trf_pkg::ERR_NONE;
        end
    end
    // flag follows cause or latched error
    assign errFlag = errCause || errLatched_q;

    // error count; only history command clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= 8'h00;
        end else if (errSetEv && hist_q != 8'hFF) begin
            hist_q <= hist_q + 8'h01;
        end else if (wrPend_q && addr_q == trf_pkg::REG_HIST) begin
            hist_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irqEv = {rejectEv, errSetEv, paramApplied && initSt_q == INIT_WAIT,
        |(offsetStored | gainStored), |(tune_q & (autoTuneDone | selfTuneDone))};
    assign rdStat = addrPh && !hwrite && haddr[7:0] == trf_pkg::REG_IRQ_STAT;

    // Sticky status, read clears, new events win
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (rdStat ? '0 : irqStat_q) | irqEv;
        end
    end
    assign irq = |(irqStat_q & irqMask_q);

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    assign addrPh = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 8'h00;
            wrPend_q <= 1'b0;
        end else begin
            wrPend_q <= addrPh && hwrite;
            if (addrPh) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
            cfg_q <= trf_pkg::CFG_RESET;
            irqMask_q <= '0;
        end else if (wrPend_q) begin
            unique case (addr_q)
                trf_pkg::REG_REQ: req_q <= {18'h0_0000, hwdata[13:0]};
                trf_pkg::REG_CFG: cfg_q <= {hwdata[31:16], 8'h00, hwdata[7:4], 1'b0, hwdata[2:0]};
                trf_pkg::REG_IRQ_MASK: irqMask_q <= hwdata[IRQ_W_LOC-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data loaded at address phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPh && !hwrite) begin
            unique case (haddr[7:0])
                trf_pkg::REG_REQ: hrdata <= req_q;
                trf_pkg::REG_FLAGS: hrdata <= {dly2, outState2, dly1, outState1,
                    gainDone_q, offDone_q, rise_q, tuneFlag};
                trf_pkg::REG_MISC: hrdata <= {26'h000_0000, errFlag, initDone_q, chanRunning};
                trf_pkg::REG_ERR: hrdata <= {errAddr_q, errCode_q};
                trf_pkg::REG_CFG: hrdata <= cfg_q;
                trf_pkg::REG_HIST: hrdata <= {24'h00_0000, hist_q};
                trf_pkg::REG_IRQ_STAT: hrdata <= {27'h000_0000, irqStat_q};
                trf_pkg::REG_IRQ_MASK: hrdata <= {27'h000_0000, irqMask_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : trf_io_flags

// [hdl/trf_on_delay.sv]
// ON-delay follower for one output state flag
`timescale 1ns/1ps
module trf_on_delay (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic tick, // Delay unit tick
    input wire logic [15:0] delayUnits, // ON-delay in units
    input wire logic src, // Undelayed output state
    output logic dly // Delayed output state
);
    logic [15:0] cnt_q;

    // Count while high; drop at once on fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            dly <= 1'b0;
        end else if (!src) begin
            cnt_q <= 16'h0000;
            dly <= 1'b0;
        end else if (cnt_q >= delayUnits) begin
            dly <= 1'b1;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : trf_on_delay

// [hdl/trf_pkg.sv]
// Constants and types of the flag bank
package trf_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int REFRESH_NS = 10_000;
    localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
    localparam int DLY_UNIT_US = 1_000;
    localparam int DLY_UNIT_CYC = (DLY_UNIT_US * 1_000) / CLK_NS;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_REQ = 8'h00;
    localparam logic [7:0] REG_FLAGS = 8'h04;
    localparam logic [7:0] REG_MISC = 8'h08;
    localparam logic [7:0] REG_ERR = 8'h0C;
    localparam logic [7:0] REG_CFG = 8'h10;
    localparam logic [7:0] REG_HIST = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;

    // ------------------------------------------------------------
    // Reset values and error codes
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_RESET = 32'h0000_0001;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_BUSY = 16'h0003;
    localparam logic [15:0] ERR_ADDR_ALL = 16'hFFFF;
    localparam logic [15:0] ERR_CLEARABLE = 16'h0006;

    // ------------------------------------------------------------
    // Interrupt bit positions
    // ------------------------------------------------------------
    localparam int IRQ_W = 5;
    localparam int IRQ_TUNE_DONE = 0;
    localparam int IRQ_LATCH_DONE = 1;
    localparam int IRQ_INIT_DONE = 2;
    localparam int IRQ_ERROR = 3;
    localparam int IRQ_REJECT = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_TEMP_IN,
        MODE_STANDARD,
        MODE_HEATCOOL,
        MODE_MIX
    } trf_mode_t;

    typedef struct packed {
        logic [15:0] onDelay;
        logic [7:0] rsvd;
        logic [3:0] selfTune;
        logic rsvd1;
        logic expanded;
        logic [1:0] mode;
    } trf_cfg_t;

    typedef struct packed {
        logic [17:0] rsvd;
        logic errorClearRequest;
        logic initialDataRequest;
        logic [3:0] gainLatchRequest;
        logic [3:0] offsetLatchRequest;
        logic [3:0] tuningInstructionFlag;
    } trf_req_t;
endpackage : trf_pkg

// [verification/tb_trf_io_flags.sv]
// Bench for the flag bank
`timescale 1ns/1ps
module tb_trf_io_flags;
    localparam int SETTLE = 450;
    logic clk_sys, rst_n, hsel, hwrite, rdPh, irq, hreadyout, hresp, paramApply, paramApplied;
    logic errCause, errEvent;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [3:0] chanRunning, autoTuneDone, autoTuneStart, selfTuneEnable, r;
    logic [3:0] outState1, outState2;
    logic [3:0] pin [6];
    logic [15:0] errCodeIn, errAddrIn;
    logic [63:0] e;
    logic [63:0] expQ [$];
    int errors = 0, n_checks = 0;
    trf_io_flags #(.DLY_UNIT_CYC(4)) dut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .chanRunning,
        .autoTuneDone, .autoTuneStart, .selfTuneEnable, .selfTuneStart(pin[0]),
        .selfTuneDone(pin[1]), .riseStart(pin[2]), .ownPidSwitch(pin[3]), .offsetStored(pin[4]),
        .gainStored(pin[5]), .outState1, .outState2, .errCause, .errEvent, .errCodeIn,
        .errAddrIn, .paramApply, .paramApplied);
    trf_plant_model plant (.clk_sys, .rst_n, .paramApply, .autoTuneStart, .paramApplied,
        .autoTuneDone);
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    // Bounded ready wait
    task automatic waitRdy;
        int n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            cmp("ready", 32'h1, 32'h0);
            close_out();
        end
    endtask : waitRdy
    // Address phase, then data phase
    task automatic busCyc(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdPh <= !w;
        waitRdy();
        rdPh <= 1'b0;
    endtask : busCyc
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
        expQ.push_back({m, ex & m});
        busCyc(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busCyc(1'b1, a, d);
    endtask : wr
    task automatic pulse(input int i, input logic [3:0] v);
        pin[i] <= v;
        wt(1);
        pin[i] <= 4'h0;
        wt(2);
    endtask : pulse
    // Request on, then off
    task automatic handshake(input logic [31:0] v);
        wr(8'h00, v);
        wt(SETTLE);
        wr(8'h00, 32'h0);
        wt(SETTLE);
    endtask : handshake
    task automatic errPulse(input logic [15:0] c);
        errCodeIn <= c;
        errAddrIn <= 16'($urandom);
        errEvent <= 1'b1;
        wt(1);
        errEvent <= 1'b0;
        wt(2);
    endtask : errPulse
    // Check reads against notes
    always @(posedge clk_sys) begin
        if (rdPh === 1'b1) begin
            if (expQ.size() == 0) begin
                cmp("note", 32'h1, 32'h0);
            end else begin
                e = expQ.pop_front();
                cmp("hrdata", e[31:0], hrdata & e[63:32]);
            end
        end
    end
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        {rst_n, hsel, hwrite, rdPh, errCause, errEvent, htrans, chanRunning} = '0;
        {haddr, hwdata, errCodeIn, errAddrIn, outState1, outState2} = '0;
        pin = '{default: 4'h0};
        hsize = 3'b010;
        void'($urandom(32'h9d12));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        wt(1);
        rd(8'h10, 32'hFFFF_FFFF, trf_pkg::CFG_RESET);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, 32'hFFFF_FFFF, 32'h0);
        wr(8'h1C, 32'h0000_0002);
        wr(8'h10, 32'h0003_00F1);
        r = 4'($urandom) | 4'h1;
        outState1 <= r;
        outState2 <= ~r;
        wt(2);
        rd(8'h04, 32'hFFFF_0000, {4'h0, ~r, 4'h0, r, 16'h0});
        wt(40);
        rd(8'h04, 32'hFFFF_0000, {~r, ~r, r, r, 16'h0});
        outState1 <= 4'h0;
        outState2 <= 4'h0;
        wt(3);
        rd(8'h04, 32'hFFFF_0000, 32'h0);
        cmp("selfTuneEnable", 32'hF, {28'h0, selfTuneEnable});
        pulse(0, 4'h2);
        rd(8'h04, 32'hF, 32'h2);
        pulse(1, 4'h2);
        rd(8'h04, 32'hF, 32'h0);
        cmp("irq", 32'h0, {31'h0, irq});
        rd(8'h18, 32'h1F, 32'h1);
        wr(8'h10, 32'h0003_00F2);
        wt(2);
        cmp("selfTuneEnable", 32'h0, {28'h0, selfTuneEnable});
        pulse(0, 4'h1);
        rd(8'h04, 32'hF, 32'h0);
        wr(8'h00, 32'hF);
        wt(SETTLE);
        rd(8'h04, 32'hF, 32'h3);
        wt(700);
        rd(8'h04, 32'hF, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h0003_00F6);
        wt(SETTLE);
        wr(8'h00, 32'h8);
        wt(SETTLE);
        rd(8'h04, 32'hF, 32'h8);
        wt(700);
        rd(8'h04, 32'hF, 32'h0);
        pulse(2, 4'h4);
        wt(5'($urandom));
        rd(8'h04, 32'hF0, 32'h40);
        pulse(3, 4'h4);
        rd(8'h04, 32'hF0, 32'h0);
        pulse(4, 4'h1);
        pulse(5, 4'h8);
        cmp("irq", 32'h1, {31'h0, irq});
        rd(8'h18, 32'h2, 32'h2);
        wt(1);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(8'h00, 32'h0000_0810);
        wt(SETTLE);
        rd(8'h04, 32'hFF00, 32'h8100);
        wr(8'h00, 32'h0);
        wt(SETTLE);
        rd(8'h04, 32'hFF00, 32'h0);
        chanRunning <= 4'h2;
        wr(8'h1C, 32'h10);
        wr(8'h00, 32'h1000);
        wt(SETTLE);
        rd(8'h08, 32'h3F, 32'h22);
        rd(8'h0C, 32'hFFFF_FFFF, 32'hFFFF_0003);
        cmp("irq", 32'h1, {31'h0, irq});
        handshake(32'h2000);
        rd(8'h08, 32'h20, 32'h0);
        rd(8'h14, 32'hFF, 32'h1);
        wr(8'h14, 32'h0);
        rd(8'h14, 32'hFF, 32'h0);
        errPulse(trf_pkg::ERR_CLEARABLE);
        rd(8'h08, 32'h20, 32'h20);
        handshake(32'h2000);
        rd(8'h08, 32'h20, 32'h0);
        errCause <= 1'b1;
        wt(2);
        rd(8'h08, 32'h20, 32'h20);
        errCause <= 1'b0;
        wt(2);
        rd(8'h08, 32'h20, 32'h0);
        chanRunning <= 4'h0;
        wr(8'h00, 32'h1000);
        wt(SETTLE);
        rd(8'h08, 32'h3F, 32'h10);
        wr(8'h00, 32'h0);
        wt(SETTLE);
        rd(8'h08, 32'h3F, 32'h0);
        errPulse(16'h0005);
        handshake(32'h2000);
        rd(8'h08, 32'h20, 32'h20);
        close_out();
    end
endmodule : tb_trf_io_flags
bind trf_io_flags trf_io_flags_monitor mon (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hreadyout, .hresp, .hrdata, .irq, .chanRunning, .autoTuneStart, .selfTuneEnable,
    .paramApply);

// [verification/trf_io_flags_monitor.sv]
// Port checker of the flag bank
`timescale 1ns/1ps
module trf_io_flags_monitor (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic hreadyout, // Ready
    input wire logic hresp, // Response
    input wire logic [31:0] hrdata, // Read data
    input wire logic irq, // Interrupt
    input wire logic [3:0] chanRunning, // Running
    input wire logic [3:0] autoTuneStart, // Tune start
    input wire logic [3:0] selfTuneEnable, // Self-tune permit
    input wire logic paramApply // Apply pulse
);
    // ------------------------------
    // Properties
    // ------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic rdTaken;
    logic wrTaken;
    // Accepted address phases
    assign rdTaken = hsel && htrans[1] && hreadyout && !hwrite;
    assign wrTaken = hsel && htrans[1] && hreadyout && hwrite;
    // Bus answer, permit, tuning and apply checks
    bus_ready_a: assert property (hreadyout) else $error("slave not ready");
    bus_okay_a: assert property (!hresp) else $error("error response");
    rdata_hold_a: assert property (!$stable(hrdata) |-> $past(rdTaken))
        else $error("stray read data");
    rdata_gap_a: assert property (rdTaken && haddr[7:0] > 8'h1C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    stune_cfg_a: assert property (!$stable(selfTuneEnable) |-> $past(wrTaken, 2))
        else $error("stray permit change");
    tune_gap_a: assert property (|autoTuneStart |=> (autoTuneStart == 4'h0) [*8])
        else $error("tuning start repeated");
    apply_gap_a: assert property (paramApply |=> !paramApply [*8])
        else $error("apply pulse repeated");
    apply_idle_a: assert property (paramApply |-> $past(chanRunning) == 4'h0)
        else $error("apply while running");
    apply_c: cover property (paramApply);
    tune_c: cover property (|autoTuneStart);
    irq_c: cover property ($rose(irq));
endmodule : trf_io_flags_monitor

// [verification/trf_plant_model.sv]
// Plant answering apply and tuning
`timescale 1ns/1ps
module trf_plant_model #(
    parameter int APPLY_CYC = 20, // Apply latency
    parameter int TUNE_CYC = 600 // Tuning length
) (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic paramApply, // Apply request
    input wire logic [3:0] autoTuneStart, // Tuning start
    output logic paramApplied, // Apply finished
    output logic [3:0] autoTuneDone // Tuning finished
);
    int applyCnt;
    int tuneCnt [4];
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            applyCnt <= 0;
            paramApplied <= 1'b0;
            autoTuneDone <= 4'h0;
            tuneCnt <= '{default: 0};
        end else begin
            paramApplied <= (applyCnt == 1);
            applyCnt <= paramApply ? APPLY_CYC : applyCnt - int'(applyCnt > 0);
            for (int i = 0; i < 4; i++) begin
                autoTuneDone[i] <= (tuneCnt[i] == 1);
                tuneCnt[i] <= autoTuneStart[i] ? TUNE_CYC : tuneCnt[i] - int'(tuneCnt[i] > 0);
            end
        end
    end
endmodule : trf_plant_model
